/* hdl/tpc_timer_pair.sv */
// even/odd timer pair with cascade and count clock select, AHB-Lite slave
// Operation
// - pair bit set joins even and odd into 32 bits; clear keeps two 16-bit
// - pair bit exists only in the even timer's control register
// - clock source bit: 1 counts external pin edges, 0 peripheral clock
// - in paired mode the odd timer's clock source bit has no effect
// - control bits 2 and 0 always read as zero
//
// Our own choices: the AHB-Lite register port and the register addresses.
module tpc_timer_pair
    import tpc_pkg::*;
#(
    parameter int unsigned W = TPC_HALF_W
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    input  wire logic        idle_mode_in,
    input  wire logic        ext_clk_even_in,
    input  wire logic        ext_clk_odd_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out
);
    typedef struct packed {
        tpc_ctrl_s                  ctrl_even;
        tpc_ctrl_s                  ctrl_odd;
        logic [TPC_SYNC_STAGES-1:0] sync_even;
        logic [TPC_SYNC_STAGES-1:0] sync_odd;
        logic                       wr_pend;
        logic                       rd_pend;
        logic                       rd_done;
        logic                       hit;
        logic [TPC_ADDR_LO_W-1:0]   addr;
        logic                       ready;
        logic                       resp;
        logic [31:0]                rdata;
    } tpc_state_s;

    tpc_state_s   s_q;
    tpc_state_s   s_d;
    logic [W-1:0] cnt_even;
    logic [W-1:0] cnt_odd;
    logic         carry_even;
    logic         inc_even;
    logic         inc_odd;
    logic         load_even;
    logic         load_odd;
    logic         edge_even;
    logic         edge_odd;
    logic         pair;
    logic         run_even;
    logic         run_odd;
    logic         accept;
    logic         wr_hit;

    // edge detect looks only at the second and third stages
    assign edge_even = s_q.sync_even[1] & ~s_q.sync_even[2];
    assign edge_odd  = s_q.sync_odd[1] & ~s_q.sync_odd[2];
    assign pair      = s_q.ctrl_even.pair_mode_select;

    // paired: idle stop honours the odd bit too, so software must clear it
    assign run_even = s_q.ctrl_even.on
                    & ~(idle_mode_in & s_q.ctrl_even.stop_idle)
                    & ~(pair & idle_mode_in & s_q.ctrl_odd.stop_idle);
    assign run_odd  = s_q.ctrl_odd.on & ~(idle_mode_in & s_q.ctrl_odd.stop_idle);

    assign inc_even = run_even
                    & (s_q.ctrl_even.count_clock_source_select ? edge_even : 1'b1);
    // odd half in pair mode follows only the even carry, its own source unused
    assign inc_odd  = pair ? carry_even
                    : run_odd & (s_q.ctrl_odd.count_clock_source_select ? edge_odd : 1'b1);

    assign accept    = hsel_in & hready_in & htrans_in[1];
    assign wr_hit    = s_q.wr_pend & s_q.hit;
    assign load_even = wr_hit & (s_q.addr == TPC_OFS_CNT_EVN);
    assign load_odd  = wr_hit & (s_q.addr == TPC_OFS_CNT_ODD);

    tpc_half #(.W(W)) u_even (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .inc_in      (inc_even),
        .load_in     (load_even),
        .load_val_in (hwdata_in[W-1:0]),
        .count_out   (cnt_even),
        .carry_out   (carry_even)
    );

    tpc_half #(.W(W)) u_odd (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .inc_in      (inc_odd),
        .load_in     (load_odd),
        .load_val_in (hwdata_in[W-1:0]),
        .count_out   (cnt_odd),
        .carry_out   ()
    );

    always_comb begin
        s_d = s_q;
        s_d.sync_even = {s_q.sync_even[TPC_SYNC_STAGES-2:0], ext_clk_even_in};
        s_d.sync_odd  = {s_q.sync_odd[TPC_SYNC_STAGES-2:0], ext_clk_odd_in};
        // write data phase: data stands now, registers take it at this edge
        if (wr_hit) begin
            unique case (s_q.addr)
                TPC_OFS_CTRL_EVN: begin
                    s_d.ctrl_even.on                        = hwdata_in[TPC_BIT_ON];
                    s_d.ctrl_even.stop_idle                 = hwdata_in[TPC_BIT_SIDL];
                    s_d.ctrl_even.pair_mode_select          = hwdata_in[TPC_BIT_PAIR];
                    s_d.ctrl_even.count_clock_source_select = hwdata_in[TPC_BIT_CSRC];
                end
                TPC_OFS_CTRL_ODD: begin
                    s_d.ctrl_odd.on                        = hwdata_in[TPC_BIT_ON];
                    s_d.ctrl_odd.stop_idle                 = hwdata_in[TPC_BIT_SIDL];
                    s_d.ctrl_odd.count_clock_source_select = hwdata_in[TPC_BIT_CSRC];
                end
                default: begin
                end
            endcase
        end
        s_d.wr_pend = 1'b0;
        // marks the cycle in which read data stands, for the checks below
        s_d.rd_done = s_q.rd_pend;
        // reads take one wait state so a write just before is always seen
        if (s_q.rd_pend) begin
            s_d.rdata   = '0;
            s_d.ready   = 1'b1;
            s_d.rd_pend = 1'b0;
            if (s_q.hit) begin
                unique case (s_q.addr)
                    TPC_OFS_CTRL_EVN: begin
                        s_d.rdata[TPC_BIT_ON]   = s_q.ctrl_even.on;
                        s_d.rdata[TPC_BIT_SIDL] = s_q.ctrl_even.stop_idle;
                        s_d.rdata[TPC_BIT_PAIR] = s_q.ctrl_even.pair_mode_select;
                        s_d.rdata[TPC_BIT_CSRC] = s_q.ctrl_even.count_clock_source_select;
                    end
                    TPC_OFS_CTRL_ODD: begin
                        s_d.rdata[TPC_BIT_ON]   = s_q.ctrl_odd.on;
                        s_d.rdata[TPC_BIT_SIDL] = s_q.ctrl_odd.stop_idle;
                        s_d.rdata[TPC_BIT_CSRC] = s_q.ctrl_odd.count_clock_source_select;
                    end
                    TPC_OFS_CNT_EVN: s_d.rdata[W-1:0] = cnt_even;
                    TPC_OFS_CNT_ODD: s_d.rdata[W-1:0] = cnt_odd;
                    default: s_d.rdata = '0;
                endcase
            end
        end
        if (accept) begin
            s_d.hit  = (haddr_in[31:TPC_ADDR_LO_W] == '0);
            s_d.addr = haddr_in[TPC_ADDR_LO_W-1:0];
            if (hwrite_in) begin
                s_d.wr_pend = 1'b1;
            end else begin
                s_d.rd_pend = 1'b1;
                s_d.ready   = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_q           <= '0;
            s_q.ctrl_even <= TPC_CTRL_RST;
            s_q.ctrl_odd  <= TPC_CTRL_RST;
            s_q.ready     <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata_out    = s_q.rdata;
    assign hreadyout_out = s_q.ready;
    assign hresp_out     = s_q.resp;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    logic rd_done;
    assign rd_done = s_q.ready & s_q.rd_done & s_q.hit;

    property p_pair_carry;
        pair && carry_even && !load_odd |=> cnt_odd == W'($past(cnt_odd) + 1'b1);
    endproperty
    a_pair_carry: assert property (p_pair_carry) else $error("odd half missed carry");

    property p_split_hold;
        !pair && !s_q.ctrl_odd.on && !load_odd |=> $stable(cnt_odd);
    endproperty
    a_split_hold: assert property (p_split_hold) else $error("odd half moved while off");

    property p_odd_no_pair;
        rd_done && s_q.addr == TPC_OFS_CTRL_ODD |-> !hrdata_out[TPC_BIT_PAIR];
    endproperty
    a_odd_no_pair: assert property (p_odd_no_pair) else $error("odd pair bit read set");

    property p_ext_hold;
        s_q.ctrl_even.count_clock_source_select && !edge_even && !load_even
            |=> $stable(cnt_even);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("even counted without pin edge");

    property p_int_count;
        run_even && !s_q.ctrl_even.count_clock_source_select && !load_even
            |=> cnt_even == W'($past(cnt_even) + 1'b1);
    endproperty
    a_int_count: assert property (p_int_count) else $error("even missed clock count");

    property p_odd_src_ignored;
        pair && !carry_even && !load_odd |=> $stable(cnt_odd);
    endproperty
    a_odd_src_ignored: assert property (p_odd_src_ignored) else $error("odd moved on own source");

    property p_rsvd_zero;
        rd_done && s_q.addr[3] == 1'b0 |-> hrdata_out[2] == 1'b0 && hrdata_out[0] == 1'b0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved control bit read set");

    property p_read_wait;
        accept && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read answer timing wrong");

    c_pair_carry: cover property (pair && carry_even);
    c_ext_count:  cover property (s_q.ctrl_even.count_clock_source_select && inc_even);
    c_ctrl_read:  cover property (rd_done && s_q.addr == TPC_OFS_CTRL_EVN);
endmodule

/* hdl/tpc_pkg.sv */
// shared constants and types for the timer pair block
package tpc_pkg;
    localparam int unsigned TPC_HALF_W       = 16;
    localparam int unsigned TPC_ADDR_LO_W    = 8;
    localparam logic [7:0]  TPC_OFS_CTRL_EVN = 8'h00;
    localparam logic [7:0]  TPC_OFS_CTRL_ODD = 8'h04;
    localparam logic [7:0]  TPC_OFS_CNT_EVN  = 8'h08;
    localparam logic [7:0]  TPC_OFS_CNT_ODD  = 8'h0c;
    localparam int unsigned TPC_BIT_ON       = 15;
    localparam int unsigned TPC_BIT_SIDL     = 13;
    localparam int unsigned TPC_BIT_PAIR     = 3;
    localparam int unsigned TPC_BIT_CSRC     = 1;
    localparam int unsigned TPC_SYNC_STAGES  = 3;

    typedef struct packed {
        logic on;
        logic stop_idle;
        logic pair_mode_select;
        logic count_clock_source_select;
    } tpc_ctrl_s;

    localparam tpc_ctrl_s TPC_CTRL_RST = '{on: 1'h0, stop_idle: 1'h0,
                                           pair_mode_select: 1'h0,
                                           count_clock_source_select: 1'h0};
endpackage

/* hdl/tpc_half.sv */
// one 16-bit half of a timer pair, with load and carry out
module tpc_half
    import tpc_pkg::*;
#(
    parameter int unsigned W = TPC_HALF_W
) (
    input  wire logic         ref_clk_in,
    input  wire logic         rst_in,
    input  wire logic         inc_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] load_val_in,
    output logic      [W-1:0] count_out,
    output logic              carry_out
);
    typedef struct packed {
        logic [W-1:0] count;
    } tpc_half_s;

    tpc_half_s s_q;
    tpc_half_s s_d;

    always_comb begin
        s_d = s_q;
        if (load_in) begin
            s_d.count = load_val_in;
        end else if (inc_in) begin
            s_d.count = s_q.count + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count_out = s_q.count;
    // carry only when this half really wraps on an increment
    assign carry_out = inc_in & ~load_in & (&s_q.count);
endmodule

/* tb/tpc_timer_pair_test.sv */
// self-checking bench for the timer pair block over its AHB-Lite port
module tpc_timer_pair_test
    import tpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk;
    logic        rst;
    logic        hsel;
    logic        hwrite;
    logic        idle_mode;
    logic        pin_e;
    logic        pin_o;
    logic        hreadyout;
    logic        hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rdv;
    logic [31:0] wv;
    logic [31:0] prev;
    logic [15:0] ld;
    logic [15:0] lfsr_q;
    int          fail_count;
    int          check_count;

    tpc_timer_pair i_dut (
        .ref_clk_in      (ref_clk),
        .rst_in          (rst),
        .hsel_in         (hsel),
        .haddr_in        (haddr),
        .htrans_in       (htrans),
        .hwrite_in       (hwrite),
        .hsize_in        (hsize),
        .hwdata_in       (hwdata),
        .hready_in       (hreadyout),
        .idle_mode_in    (idle_mode),
        .ext_clk_even_in (pin_e),
        .ext_clk_odd_in  (pin_o),
        .hrdata_out      (hrdata),
        .hreadyout_out   (hreadyout),
        .hresp_out       (hresp)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction

    task automatic complete_run();
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one single transfer; only the bench's watchdog ends a wait that never returns
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            @(posedge ref_clk);
        end
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            @(posedge ref_clk);
        end
        rdv = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h00000000);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] ofs, input logic [31:0] exp);
        bus(1'b0, ofs, 32'h00000000);
        chk(nm, rdv, exp);
    endtask

    // pulses held 4 cycles high and low so the 3-stage synchroniser sees each edge
    task automatic pulse(input logic odd, input int n);
        repeat (n) begin
            if (odd)
                pin_o <= 1'b1;
            else
                pin_e <= 1'b1;
            repeat (4) @(posedge ref_clk);
            pin_o <= 1'b0;
            pin_e <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        complete_run();
    end

    initial begin
        {rst, hsel, hwrite, idle_mode, pin_e, pin_o} = 6'h20;
        {htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        lfsr_q = 16'h0047;
        fail_count = 0;
        check_count = 0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd_chk("unmapped", 8'h40, 32'h00000000);
        for (int i = 0; i < 5; i++) begin
            ld = rnd();
            wv = (i == 0) ? 32'hffff7fff : ({ld, rnd()} & 32'hffff7fff);
            bus(1'b1, TPC_OFS_CTRL_EVN, wv);
            @(posedge ref_clk);
            rd_chk("even ctrl", TPC_OFS_CTRL_EVN, wv & 32'h0000200a);
            bus(1'b1, TPC_OFS_CTRL_ODD, wv);
            @(posedge ref_clk);
            rd_chk("odd ctrl", TPC_OFS_CTRL_ODD, wv & 32'h00002002);
        end
        bus(1'b1, TPC_OFS_CTRL_ODD, 32'h00000000);
        ld = rnd();
        bus(1'b1, TPC_OFS_CNT_EVN, {16'hffff, ld});
        bus(1'b1, TPC_OFS_CTRL_EVN, 32'h00008002);
        pulse(1'b1, 2);
        pulse(1'b0, 3);
        rd_chk("even pin count", TPC_OFS_CNT_EVN, {16'h0000, ld + 16'h0003});
        bus(1'b1, TPC_OFS_CTRL_EVN, 32'h00008000);
        bus(1'b0, TPC_OFS_CNT_EVN, 32'h00000000);
        prev = rdv;
        bus(1'b0, TPC_OFS_CNT_EVN, 32'h00000000);
        // back-to-back reads sample the count three clocks apart
        chk("even internal runs", rdv, {16'h0000, prev[15:0] + 16'h0003});
        // split halves: even wrap must not carry
        bus(1'b1, TPC_OFS_CTRL_EVN, 32'h00008002);
        bus(1'b1, TPC_OFS_CTRL_ODD, 32'h00008002);
        bus(1'b1, TPC_OFS_CNT_EVN, 32'h0000ffff);
        bus(1'b1, TPC_OFS_CNT_ODD, 32'h00000007);
        pulse(1'b0, 2);
        rd_chk("split even", TPC_OFS_CNT_EVN, 32'h00000001);
        rd_chk("split odd", TPC_OFS_CNT_ODD, 32'h00000007);
        pulse(1'b1, 1);
        rd_chk("split odd pin", TPC_OFS_CNT_ODD, 32'h00000008);
        // paired: odd keeps its pin source bit set, which must be ignored
        bus(1'b1, TPC_OFS_CTRL_EVN, 32'h0000800a);
        bus(1'b1, TPC_OFS_CNT_EVN, 32'h0000fffe);
        bus(1'b1, TPC_OFS_CNT_ODD, 32'h00000005);
        pulse(1'b1, 2);
        rd_chk("pair odd pin", TPC_OFS_CNT_EVN, 32'h0000fffe);
        rd_chk("pair odd still", TPC_OFS_CNT_ODD, 32'h00000005);
        pulse(1'b0, 3);
        rd_chk("pair low", TPC_OFS_CNT_EVN, 32'h00000001);
        rd_chk("pair high", TPC_OFS_CNT_ODD, 32'h00000006);
        idle_mode <= 1'b1;
        bus(1'b1, TPC_OFS_CTRL_ODD, 32'h00002000);
        pulse(1'b0, 2);
        rd_chk("pair idle stop", TPC_OFS_CNT_EVN, 32'h00000001);
        bus(1'b1, TPC_OFS_CTRL_ODD, 32'h00000000);
        pulse(1'b0, 2);
        rd_chk("pair idle run", TPC_OFS_CNT_EVN, 32'h00000003);
        complete_run();
    end
endmodule
